// *** design/dmba_pkg.sv ***
// Constants for the data memory bank addressing block.
package dmba_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BANK_W = 2;
    localparam int unsigned PHYS_W = BANK_W + ADDR_W;
    localparam logic [7:0] OFS_WINDOW_ZERO  = 8'h00;
    localparam logic [7:0] OFS_POINTER_ZERO = 8'h01;
    localparam logic [7:0] OFS_WINDOW_ONE   = 8'h02;
    localparam logic [7:0] OFS_POINTER_ONE  = 8'h03;
    localparam logic [7:0] OFS_BANK_SELECT  = 8'h04;
    localparam logic [7:0] OFS_EEPROM_CTRL  = 8'h40;
    localparam logic [7:0] SFR_LAST         = 8'h5F;
    localparam logic [7:0] RESET_BANK_SELECT = 8'h00;
    localparam logic [7:0] RESET_POINTER     = 8'h00;
    localparam logic [7:0] WINDOW_READ_VALUE = 8'h00;
    localparam logic [1:0] BANK_ZERO     = 2'h0;
    localparam logic [1:0] BANK_ONE      = 2'h1;
    localparam logic [1:0] BANK_TWO      = 2'h2;
    localparam logic [1:0] BANK_RESERVED = 2'h3;
    // Low two bank bits implemented in the three-bank part.
    localparam logic [7:0] BANK_MASK_THREE = 8'h03;
    localparam logic [7:0] BANK_MASK_TWO   = 8'h01;
endpackage : dmba_pkg

// *** design/dmba_decode.sv ***
`timescale 1ns/1ps
// Combinational address resolver for direct and indirect data accesses.
module dmba_decode (
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] pointer_zero,
    input  wire logic [7:0] pointer_one,
    input  wire logic [1:0] bank_sel,
    output logic [9:0]      phys_addr,
    output logic            window_hit,
    output logic            null_target,
    output logic            is_sfr,
    output logic            eeprom_ctrl_hit
);
    logic [7:0] offset;
    logic [1:0] bank;

    // Windows are never the target themselves; they redirect through pointers.
    always_comb begin
        window_hit = 1'b0;
        offset     = cpu_addr;
        bank       = dmba_pkg::BANK_ZERO;
        if (cpu_addr == dmba_pkg::OFS_WINDOW_ZERO) begin
            window_hit = 1'b1;
            offset     = pointer_zero;
            bank       = dmba_pkg::BANK_ZERO;
        end else if (cpu_addr == dmba_pkg::OFS_WINDOW_ONE) begin
            window_hit = 1'b1;
            offset     = pointer_one;
            bank       = bank_sel;
        end
    end

    // A window pointing at a window reads zero and writes nothing.
    assign null_target = window_hit &&
        (offset == dmba_pkg::OFS_WINDOW_ZERO ||
         offset == dmba_pkg::OFS_WINDOW_ONE);
    // Special function area is bank independent, except the EEPROM control.
    assign is_sfr = (offset <= dmba_pkg::SFR_LAST);
    assign eeprom_ctrl_hit = (offset == dmba_pkg::OFS_EEPROM_CTRL) &&
        (bank == dmba_pkg::BANK_ONE);
    // Bank forms the high part outside the special area, offset the low part.
    assign phys_addr = is_sfr ? {dmba_pkg::BANK_ZERO, offset}
                              : {bank, offset};
endmodule : dmba_decode

// *** design/dmba_bank.sv ***
`timescale 1ns/1ps
// Data memory bank addressing: pointers, bank select and address routing.
module dmba_bank #(
    parameter bit THREE_BANK = 1'b1
) (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       sys_reset,
    input  wire logic       wdt_reset,
    input  wire logic       power_down,
    input  wire logic [7:0] cpu_addr,
    input  wire logic       cpu_rd,
    input  wire logic       cpu_wr,
    input  wire logic [7:0] cpu_wdata,
    output logic [7:0]      cpu_rdata,
    input  wire logic [7:0] ext_rdata,
    output logic [9:0]      mem_addr,
    output logic            mem_rd,
    output logic            mem_wr,
    output logic            mem_is_sfr,
    output logic            eeprom_ctrl_sel,
    output logic [7:0]      mem_wdata,
    output logic [1:0]      data_bank,
    output logic [1:0]      prog_bank
);
    logic [7:0] memory_pointer_zero_r;
    logic [7:0] memory_pointer_one_r;
    logic [7:0] bank_select_r;
    logic [7:0] bank_select_nxt;
    logic [7:0] bank_mask;
    logic [9:0] phys_addr;
    logic       window_hit;
    logic       null_target;
    logic       is_sfr;
    logic       eeprom_hit;
    logic       eeprom_any;
    logic [7:0] local_rdata;
    logic       local_hit;
    logic       reset_bank;

    // Overview of the access path.
    // A data access from the core presents one address, one strobe and,
    // for a write, one byte. The address is resolved in a single step:
    // the decoder decides whether the access goes through a window, which
    // pointer supplies the offset, and which bank is the high part.
    // Nothing here is pipelined. The resolved address, the strobes to the
    // memory and the read data all follow the core's inputs within the
    // same cycle. This keeps the core's one-cycle data access, at the
    // price of a longer combinational path from address to read data.
    //
    // Local storage.
    // Only the two pointers and the bank select live in this block. The
    // windows have no storage of their own; they exist only as decode
    // slots. Every other special register in the low area belongs to the
    // blocks around this one, which see the resolved address, the strobes
    // and the special-area flag on the memory port.
    //
    // Window loops.
    // A pointer may hold the offset of a window. Following it would make
    // the access resolve again through the window, without end, so such a
    // target is cut off: the read returns zero and the write is dropped.
    // A pointer that holds the offset of a pointer or of the bank select
    // reaches that register as an ordinary read or write.
    //
    // Reset.
    // The asynchronous reset clears everything. The synchronous reset
    // request clears only the bank select, and only when it is not a
    // watchdog time-out during power down. A bank select write on the same
    // edge as a clearing reset request loses; software must repeat it afterwards.
    //
    // Limitations.
    // The reserved bank code passes through unchanged. An access with
    // that code lands in whatever the memory behind this block maps there;
    // software must not select it. The two-bank build masks the high bit
    // away, so the reserved code cannot be reached there at all.

    assign bank_mask = THREE_BANK ? dmba_pkg::BANK_MASK_THREE
                                  : dmba_pkg::BANK_MASK_TWO;

    dmba_decode u_decode (
        .cpu_addr        (cpu_addr),
        .pointer_zero    (memory_pointer_zero_r),
        .pointer_one     (memory_pointer_one_r),
        .bank_sel        (bank_select_r[1:0]),
        .phys_addr       (phys_addr),
        .window_hit      (window_hit),
        .null_target     (null_target),
        .is_sfr          (is_sfr),
        .eeprom_ctrl_hit (eeprom_hit)
    );

    // The EEPROM control slot is dead outside bank one.
    assign eeprom_any = phys_addr[7:0] == dmba_pkg::OFS_EEPROM_CTRL;

    // Local registers answer only for the resolved address in the SFR area.
    assign local_hit = is_sfr && !null_target &&
        (phys_addr[7:0] == dmba_pkg::OFS_POINTER_ZERO ||
         phys_addr[7:0] == dmba_pkg::OFS_POINTER_ONE  ||
         phys_addr[7:0] == dmba_pkg::OFS_BANK_SELECT);

    // Writes to unimplemented bank bits are dropped by the mask, bit by
    // bit, so the upper bits of the register are always zero and a read
    // needs no masking of its own.
    for (genvar gi = 0; gi < dmba_pkg::DATA_W; gi++) begin : g_bank_bit
        assign bank_select_nxt[gi] = cpu_wdata[gi] & bank_mask[gi];
    end

    // Watchdog resets during power down must keep the bank, so that
    // software resuming after a wake sees the bank it left.
    assign reset_bank = sys_reset && !(wdt_reset && power_down);

    // Pointer zero: ordinary register, writable directly or through window.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            memory_pointer_zero_r <= dmba_pkg::RESET_POINTER;
        end else if (cpu_wr && local_hit &&
                     phys_addr[7:0] == dmba_pkg::OFS_POINTER_ZERO) begin
            memory_pointer_zero_r <= cpu_wdata;
        end
    end

    // Pointer one: same treatment as pointer zero.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            memory_pointer_one_r <= dmba_pkg::RESET_POINTER;
        end else if (cpu_wr && local_hit &&
                     phys_addr[7:0] == dmba_pkg::OFS_POINTER_ONE) begin
            memory_pointer_one_r <= cpu_wdata;
        end
    end

    // Bank select register with conditional synchronous reset.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bank_select_r <= dmba_pkg::RESET_BANK_SELECT;
        end else if (reset_bank) begin
            bank_select_r <= dmba_pkg::RESET_BANK_SELECT;
        end else if (cpu_wr && local_hit &&
                     phys_addr[7:0] == dmba_pkg::OFS_BANK_SELECT) begin
            bank_select_r <= bank_select_nxt;
        end
    end

    // Local read data; reserved bits are already zero in the register.
    always_comb begin
        case (phys_addr[7:0])
            dmba_pkg::OFS_POINTER_ZERO: local_rdata = memory_pointer_zero_r;
            dmba_pkg::OFS_POINTER_ONE:  local_rdata = memory_pointer_one_r;
            dmba_pkg::OFS_BANK_SELECT:  local_rdata = bank_select_r;
            default: begin
                local_rdata = dmba_pkg::WINDOW_READ_VALUE;
            end
        endcase
    end

    // Read data mux: window loops and the hidden EEPROM slot give zero, local registers, else memory.
    always_comb begin
        if (null_target) begin
            cpu_rdata = dmba_pkg::WINDOW_READ_VALUE;
        end else if (local_hit) begin
            cpu_rdata = local_rdata;
        end else if (eeprom_any && !eeprom_hit) begin
            cpu_rdata = dmba_pkg::WINDOW_READ_VALUE;
        end else begin
            cpu_rdata = ext_rdata;
        end
    end

    // Memory port.
    // The address and write data pass straight through. The strobes are
    // withheld in three cases: the access hits a register kept here, it
    // follows a window into a window, or it reaches the EEPROM control
    // slot outside bank one. In the last case the slot reads as zero, so
    // code running in another bank cannot disturb EEPROM operation by a
    // stray write through the second window.
    //
    // The special-area flag lets the surrounding registers decode the low
    // offsets without looking at the bank part, which is already forced
    // to zero there.
    //
    // Memory port strobes; suppressed for local, looped or hidden slots.
    assign mem_addr        = phys_addr;
    assign mem_wdata       = cpu_wdata;
    assign mem_is_sfr      = is_sfr;
    assign eeprom_ctrl_sel = eeprom_hit;
    assign mem_rd = cpu_rd && !null_target && !local_hit &&
                    !(eeprom_any && !eeprom_hit);
    assign mem_wr = cpu_wr && !null_target && !local_hit &&
                    !(eeprom_any && !eeprom_hit);
    // The same register steers program memory banking. Software that
    // changes the data bank therefore also moves the program bank, and
    // must do so only where the next fetch is valid in either bank.
    assign data_bank = bank_select_r[1:0];
    assign prog_bank = bank_select_r[1:0];
endmodule : dmba_bank

// *** testbench/dmba_bank_assertions.sv ***
// Port-level assertions for the bank addressing block.
`timescale 1ns/1ps
module dmba_bank_assertions #(
    parameter bit THREE_BANK = 1'b1
) (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic       sys_reset,
    input wire logic       wdt_reset,
    input wire logic       power_down,
    input wire logic [7:0] cpu_addr,
    input wire logic       cpu_rd,
    input wire logic       cpu_wr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic [9:0] mem_addr,
    input wire logic       mem_rd,
    input wire logic       mem_wr,
    input wire logic       mem_is_sfr,
    input wire logic       eeprom_ctrl_sel,
    input wire logic [1:0] data_bank,
    input wire logic [1:0] prog_bank
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // A clearing reset in the same cycle wins over the write, so any reset is excluded.
    sequence s_bank_set;
        cpu_wr && cpu_addr == 8'h04 && !sys_reset;
    endsequence
    sequence s_hold_reset;
        sys_reset && wdt_reset && power_down && !cpu_wr;
    endsequence
    bank_write_a: assert property (s_bank_set |=>
        {6'h00, data_bank} == ($past(cpu_wdata) & (THREE_BANK ? 8'h03 : 8'h01)))
        else $error("bank select write not applied");
    wdt_hold_a: assert property (s_hold_reset |=> $stable(data_bank))
        else $error("bank lost on sleeping watchdog reset");
    reset_clear_a: assert property (sys_reset &&
        !(wdt_reset && power_down) |=> data_bank == 2'h0)
        else $error("bank select not cleared by reset");
    prog_share_a: assert property (prog_bank == data_bank)
        else $error("program bank differs from data bank");
    direct_bank0_a: assert property ((cpu_rd || cpu_wr) &&
        cpu_addr > 8'h04 |-> mem_addr == {2'h0, cpu_addr})
        else $error("direct access left bank zero");
    win_zero_a: assert property (cpu_addr == 8'h00 &&
        (mem_rd || mem_wr) |-> mem_addr[9:8] == 2'h0)
        else $error("first window left bank zero");
    win_one_a: assert property (cpu_addr == 8'h02 &&
        (mem_rd || mem_wr) && !mem_is_sfr |-> mem_addr[9:8] == data_bank)
        else $error("second window missed the selected bank");
    upper_zero_a: assert property (cpu_rd && cpu_addr == 8'h04 |->
        cpu_rdata[7:2] == 6'h00) else $error("unused bank bits read set");
    sfr_common_a: assert property ((mem_rd || mem_wr) |->
        mem_is_sfr == (mem_addr[7:0] <= 8'h5f) &&
        (!mem_is_sfr || mem_addr[9:8] == 2'h0)) else $error("sfr decode");
    eeprom_vis_a: assert property (eeprom_ctrl_sel |->
        data_bank == 2'h1 && cpu_addr == 8'h02 && mem_addr[7:0] == 8'h40)
        else $error("eeprom control seen outside bank one");
endmodule : dmba_bank_assertions

bind dmba_bank dmba_bank_assertions #(.THREE_BANK(THREE_BANK)) u_chk (.*);

// *** testbench/dmba_mem_model.sv ***
// Behavioural data memory answering the bank addressing block.
`timescale 1ns/1ps
module dmba_mem_model (
    input  wire logic       core_clk,
    input  wire logic [9:0] mem_addr,
    input  wire logic       mem_rd,
    input  wire logic       mem_wr,
    input  wire logic [7:0] mem_wdata,
    output logic      [7:0] ext_rdata
);
    logic [7:0] ram [1024];
    // Outside a read the cell shows inverted, so a stale byte never passes.
    assign ext_rdata = mem_rd ? ram[mem_addr] : ~ram[mem_addr];
    // A write lands at the edge that takes the strobe.
    always_ff @(posedge core_clk) begin
        if (mem_wr) begin
            ram[mem_addr] <= mem_wdata;
        end
    end
endmodule : dmba_mem_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the bank addressing block.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic        core_clk, arst_n, sys_reset, wdt_reset, power_down;
    logic        cpu_rd, cpu_wr, mem_rd, mem_wr, mem_is_sfr, eeprom_ctrl_sel;
    logic [7:0]  cpu_addr, cpu_wdata, cpu_rdata, ext_rdata, mem_wdata, exp_v;
    logic [9:0]  mem_addr;
    logic [1:0]  data_bank, prog_bank;
    logic [7:0]  expq [$];
    logic [31:0] seed = 32'hfa94;
    int          miscompares = 0;
    int          checks_done = 0;
    dmba_bank #(.THREE_BANK(1'b1)) uut (.*);
    dmba_mem_model u_mem (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic acc(input logic r, input logic [7:0] a, d);
        @(posedge core_clk);
        cpu_rd <= r;
        cpu_wr <= !r;
        cpu_addr <= a;
        cpu_wdata <= d;
    endtask : acc
    task automatic rd(input logic [7:0] a, e);
        acc(1'b1, a, 8'h00);
        expq.push_back(e);
    endtask : rd
    // Sleeping-watchdog reset when s is set, awake watchdog reset otherwise.
    task automatic sreset(input logic s);
        @(posedge core_clk);
        {cpu_rd, cpu_wr, sys_reset, wdt_reset, power_down} <= {4'h3, s};
        @(posedge core_clk);
        sys_reset <= 1'b0;
    endtask : sreset
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // A read is judged at the edge closing its cycle; data is combinational.
    always @(posedge core_clk) begin
        if (cpu_rd === 1'b1) begin
            exp_v = expq.pop_front();
            `CHK(cpu_rdata, exp_v)
        end
    end
    initial begin
        repeat (400) @(posedge core_clk);
        miscompares++;
        final_report();
    end
    initial begin
        {arst_n, sys_reset, wdt_reset, power_down, cpu_rd, cpu_wr} = '0;
        {cpu_addr, cpu_wdata} = '0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(8'h04, 8'h00);
        seed = lfsr(seed);
        acc(1'b0, 8'h03, seed[7:0]);
        rd(8'h03, seed[7:0]);
        // Every bank code, with random junk in the unused upper bits.
        for (int b = 0; b < 4; b++) begin
            seed = lfsr(seed);
            acc(1'b0, 8'h04, {seed[7:2], b[1:0]});
            rd(8'h04, {6'h00, b[1:0]});
        end
        // One pointer offset holds a distinct byte in each bank.
        for (int b = 0; b < 6; b++) begin
            acc(1'b0, 8'h04, {6'h00, 2'(b % 3)});
            if (b < 3) acc(1'b0, 8'h03, 8'h80);
            if (b < 3) acc(1'b0, 8'h02, {6'h28, 2'(b)});
            else rd(8'h02, {6'h28, 2'(b - 3)});
        end
        rd(8'h80, 8'ha0);
        acc(1'b0, 8'h01, 8'h80);
        rd(8'h00, 8'ha0);
        acc(1'b0, 8'h03, 8'h10);
        acc(1'b0, 8'h02, 8'h3c);
        rd(8'h10, 8'h3c);
        acc(1'b0, 8'h04, 8'h01);
        acc(1'b0, 8'h03, 8'h40);
        acc(1'b0, 8'h02, 8'h5c);
        rd(8'h02, 8'h5c);
        acc(1'b0, 8'h04, 8'h00);
        rd(8'h02, 8'h00);
        acc(1'b0, 8'h03, 8'h02);
        acc(1'b0, 8'h02, 8'h77);
        rd(8'h02, 8'h00);
        acc(1'b0, 8'h01, 8'h00);
        rd(8'h00, 8'h00);
        acc(1'b0, 8'h04, 8'h02);
        sreset(1'b1);
        rd(8'h04, 8'h02);
        sreset(1'b0);
        rd(8'h04, 8'h00);
        acc(1'b0, 8'h05, 8'h00);
        repeat (2) @(posedge core_clk);
        final_report();
    end
endmodule : tb_top
